// >>> hdl/dams_pkg.sv
// constants, register map and carrier types of the pll mode sequencer
// assumes a 20 MHz apb clock and analog/digital loop status from the core
// What this block does
// - after init every enabled analog loop except a cascaded downstream one locks to crystal, free-runs until digital control
// - enabled digital loop starts acquisition on the valid reference of its own channel
// - phase digitizer error becomes correction word; filter output steers numerator
// - independent channels lock and unlock without disturbing each other
// - cascaded: all locked means outputs follow main loop's reference
// - cascaded loop holds lock tracking upstream offset while within limits
// - resonator held at center frequency while downstream analog loops acquire
// - after downstream lock, resonator locks to crystal and free-runs
// - acquisition starts only after reference valid longer than minimum time
// - first correction unfiltered cancels phase error; later ones filtered
// - resonator free-run offset passes downstream even when downstream reports lock
// - either conventional analog loop may serve as cascade upstream
// - disabled downstream digital loop: oscillator tracks resonator domain
// - analog-only mode: digital loops inactive, no influence on analog loops
// - analog-only: analog loops lock one by one in start priority order
// - denominator select clear picks 24-bit programmable, set picks fixed 40-bit
// - analog-only: oscillator frequency adjust through register writes
// - uncascaded analog loop locks to crystal in priority order, runs independent
// - digital-controlled loop uses fixed 40-bit denominator, numerator steered
package dams_pkg;
  localparam int NLOOP = 3;
  localparam int MAIN = 2;
  localparam int AW = 8;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_ENABLE = 8'h04;
  localparam logic [AW-1:0] OFS_PRIO = 8'h08;
  localparam logic [AW-1:0] OFS_STATUS = 8'h0C;
  localparam logic [AW-1:0] OFS_DCO0 = 8'h10;
  localparam logic [AW-1:0] OFS_DCO1 = 8'h14;
  localparam logic [AW-1:0] OFS_DCO2 = 8'h18;
  localparam logic [AW-1:0] OFS_VALID_TIME = 8'h20;
  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int MODE_LSB = 0;
  localparam int DENSEL_LSB = 4;
  localparam int UPSEL_LSB = 8;
  localparam int DLEN_LSB = 0;
  localparam int ALEN_LSB = 4;
  localparam int CASC_LSB = 8;
  localparam int DLOCK_LSB = 0;
  localparam int ALOCK_LSB = 4;
  localparam int FREERUN_LSB = 8;
  localparam int HOLDC_LSB = 12;
  localparam logic [31:0] VALID_TIME_RST = 32'h0000_4E20;
  localparam int NUM_W = 24;
  localparam int CORR_W = 24;
  localparam int FILT_SH = 4;
  typedef enum logic [1:0]
  {
    MODE_INDEP = 2'b00,
    MODE_DCASC = 2'b01,
    MODE_ACASC = 2'b10,
    MODE_AONLY = 2'b11
  } dams_mode_t;
  typedef enum logic [2:0]
  {
    ST_INIT = 3'b000,
    ST_CENTER = 3'b001,
    ST_ALOCK = 3'b010,
    ST_FREERUN = 3'b011,
    ST_RUN = 3'b100
  } dams_state_t;
  typedef struct packed
  {
    logic valid;
    logic signed [CORR_W-1:0] phase_err;
  } dams_phase_t;
endpackage : dams_pkg

// >>> hdl/dams_top.sv
// mode and lock sequencer for three digital loops paired with analog loops
// assumes status inputs from the analog core arrive asynchronously
`timescale 1ns/10ps
module dams_top
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // loop status from the analog core
  input wire logic [2:0] reference_input_valid,
  input wire logic [2:0] analog_lock_in,
  input wire dams_pkg::dams_phase_t [2:0] phase_time_digitizer,
  // loop control to the analog core
  output logic [2:0] analog_loop_enable,
  output logic [2:0] crystal_osc_select,
  output logic center_hold,
  output logic [2:0] denominator_select,
  output logic [2:0] digital_active,
  output logic [2:0] numerator_load,
  output logic [71:0] numerator
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] mode_r;
  logic [31:0] enable_r;
  logic [31:0] prio_r;
  logic [31:0] valid_time_r;
  logic [23:0] dco_r [3];
  logic [2:0] sync1_r, sync2_r, sync3_r;
  logic [2:0] lsync1_r, lsync2_r, lsync3_r;
  logic [2:0] ref_ok_r;
  logic [2:0] alock_r;
  logic [2:0] dlock_r;
  logic [2:0] first_r;
  logic [2:0] acq_r;
  logic [2:0] started_r;
  logic [31:0] vcnt_r [3];
  logic signed [23:0] acc_r [3];
  logic [1:0] prio_idx_r;
  dams_pkg::dams_state_t state_r;
  dams_pkg::dams_mode_t mode;
  logic [2:0] casc, dl_en, al_en;
  logic [1:0] upsel;
  logic wr_en, rd_en;
  assign mode = dams_pkg::dams_mode_t'(mode_r[1:0]);
  assign casc = enable_r[dams_pkg::CASC_LSB +: 3];
  assign dl_en = enable_r[dams_pkg::DLEN_LSB +: 3]
    & {3{mode != dams_pkg::MODE_AONLY}};
  assign al_en = enable_r[dams_pkg::ALEN_LSB +: 3];
  assign upsel = mode_r[dams_pkg::UPSEL_LSB +: 2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  // ****************************************************************
  // apb slave: zero wait, unmapped reads zero and flag error
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= 32'h0000_0000;
      enable_r <= 32'h0000_0000;
      prio_r <= 32'h0000_0000;
      valid_time_r <= dams_pkg::VALID_TIME_RST;
      dco_r[0] <= 24'h000000;
      dco_r[1] <= 24'h000000;
      dco_r[2] <= 24'h000000;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        dams_pkg::OFS_MODE: mode_r <= pwdata;
        dams_pkg::OFS_ENABLE: enable_r <= pwdata;
        dams_pkg::OFS_PRIO: prio_r <= pwdata;
        dams_pkg::OFS_VALID_TIME: valid_time_r <= pwdata;
        dams_pkg::OFS_DCO0: dco_r[0] <= pwdata[23:0];
        dams_pkg::OFS_DCO1: dco_r[1] <= pwdata[23:0];
        dams_pkg::OFS_DCO2: dco_r[2] <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  logic [31:0] rdata_nxt;
  logic err_nxt;
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    unique case (paddr)
      dams_pkg::OFS_MODE: rdata_nxt = mode_r;
      dams_pkg::OFS_ENABLE: rdata_nxt = enable_r;
      dams_pkg::OFS_PRIO: rdata_nxt = prio_r;
      dams_pkg::OFS_VALID_TIME: rdata_nxt = valid_time_r;
      dams_pkg::OFS_STATUS:
        rdata_nxt = {17'h00000, state_r, 1'b0, alock_r & ~ref_ok_r,
          1'b0, alock_r, 1'b0, dlock_r};
      dams_pkg::OFS_DCO0: rdata_nxt = {8'h00, dco_r[0]};
      dams_pkg::OFS_DCO1: rdata_nxt = {8'h00, dco_r[1]};
      dams_pkg::OFS_DCO2: rdata_nxt = {8'h00, dco_r[2]};
      default: err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & err_nxt;
      // refused writes clear read data too, so an error never shows stale data
      if (psel && !penable && (rd_en || err_nxt))
        prdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // input synchronisers, change counted when stages 2 and 3 agree
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
      lsync1_r <= 3'h0;
      lsync2_r <= 3'h0;
      lsync3_r <= 3'h0;
      ref_ok_r <= 3'h0;
      alock_r <= 3'h0;
    end
    else
    begin
      sync1_r <= reference_input_valid;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lsync1_r <= analog_lock_in;
      lsync2_r <= lsync1_r;
      lsync3_r <= lsync2_r;
      ref_ok_r <= (sync2_r & sync3_r) | (ref_ok_r & (sync2_r | sync3_r));
      alock_r <= (lsync2_r & lsync3_r) | (alock_r & (lsync2_r | lsync3_r));
    end
  end

  // ****************************************************************
  // start-up sequencer for the analog loops
  // ****************************************************************
  logic [1:0] cur_loop;
  assign cur_loop = prio_r[2*prio_idx_r +: 2];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= dams_pkg::ST_INIT;
      prio_idx_r <= 2'd0;
      started_r <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        dams_pkg::ST_INIT:
        begin
          started_r <= 3'h0;
          prio_idx_r <= 2'd0;
          if (|al_en)
            state_r <= (mode == dams_pkg::MODE_ACASC) ?
              dams_pkg::ST_CENTER : dams_pkg::ST_ALOCK;
        end
        dams_pkg::ST_CENTER:
          state_r <= dams_pkg::ST_ALOCK;
        dams_pkg::ST_ALOCK:
        begin
          // one loop at a time in start priority order
          if (prio_idx_r == 2'd3)
            state_r <= dams_pkg::ST_FREERUN;
          else if (cur_loop > 2'd2 || !al_en[cur_loop])
            prio_idx_r <= prio_idx_r + 2'd1;
          else
          begin
            started_r[cur_loop] <= 1'b1;
            if (alock_r[cur_loop])
              prio_idx_r <= prio_idx_r + 2'd1;
          end
        end
        dams_pkg::ST_FREERUN:
          state_r <= dams_pkg::ST_RUN;
        dams_pkg::ST_RUN:
          if (al_en == 3'h0)
            state_r <= dams_pkg::ST_INIT;
      endcase
    end
  end

  // ****************************************************************
  // per-loop digital acquisition and correction path
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_loop
      logic up_locked;
      // cascaded loops keep lock on their own status only; upstream
      // free-run offset is passed through unfiltered by design
      assign up_locked = (mode == dams_pkg::MODE_INDEP) ? 1'b1 :
        (g == dams_pkg::MAIN) ? 1'b1 : alock_r[dams_pkg::MAIN];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          vcnt_r[g] <= 32'h0000_0000;
          acq_r[g] <= 1'b0;
          first_r[g] <= 1'b1;
          acc_r[g] <= 24'sh000000;
          dlock_r[g] <= 1'b0;
        end
        else if (!dl_en[g] || state_r != dams_pkg::ST_RUN)
        begin
          vcnt_r[g] <= 32'h0000_0000;
          acq_r[g] <= 1'b0;
          first_r[g] <= 1'b1;
          acc_r[g] <= 24'sh000000;
          dlock_r[g] <= 1'b0;
        end
        else
        begin
          // independent per channel: only cross-channel term is up_locked, loop MAIN's analog lock when cascaded
          if (!ref_ok_r[g])
            vcnt_r[g] <= 32'h0000_0000;
          else if (vcnt_r[g] <= valid_time_r)
            vcnt_r[g] <= vcnt_r[g] + 32'h0000_0001;
          if (vcnt_r[g] > valid_time_r && up_locked)
            acq_r[g] <= 1'b1;
          else if (!ref_ok_r[g])
            acq_r[g] <= 1'b0;
          if (acq_r[g] && phase_time_digitizer[g].valid)
          begin
            first_r[g] <= 1'b0;
            if (first_r[g])
              acc_r[g] <= acc_r[g] - phase_time_digitizer[g].phase_err;
            else
              acc_r[g] <= acc_r[g] - (phase_time_digitizer[g].phase_err
                >>> dams_pkg::FILT_SH);
          end
          dlock_r[g] <= acq_r[g] & alock_r[g] & ~first_r[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          numerator[24*g +: 24] <= 24'h000000;
          numerator_load[g] <= 1'b0;
          denominator_select[g] <= 1'b0;
          digital_active[g] <= 1'b0;
          analog_loop_enable[g] <= 1'b0;
          crystal_osc_select[g] <= 1'b1;
        end
        else
        begin
          analog_loop_enable[g] <= al_en[g] & started_r[g];
          // cascaded downstream follows the selected upstream, else crystal
          crystal_osc_select[g] <= ~(casc[g] && mode != dams_pkg::MODE_INDEP
            && g != upsel);
          digital_active[g] <= dl_en[g] & acq_r[g];
          denominator_select[g] <= (dl_en[g] & acq_r[g]) ? 1'b1 :
            mode_r[dams_pkg::DENSEL_LSB + g];
          numerator_load[g] <= acq_r[g] | ~dl_en[g];
          numerator[24*g +: 24] <= (dl_en[g] & acq_r[g]) ?
            dco_r[g] + acc_r[g] : dco_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      center_hold <= 1'b0;
    else
      center_hold <= (mode == dams_pkg::MODE_ACASC) &&
        (state_r == dams_pkg::ST_CENTER || state_r == dams_pkg::ST_ALOCK);
  end
endmodule : dams_top

// >>> testbench/dams_assertions.sv
// checker: apb and loop sequencing relations at the top ports
// assumes it is bound into dams_top
`timescale 1ns/10ps
module dams_assertions
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // loops
  input wire logic [2:0] reference_input_valid,
  input wire logic [2:0] crystal_osc_select,
  input wire logic [2:0] digital_active
);
  logic aonly_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mode is tracked from completed writes, the only view of it at the ports
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aonly_r <= 1'b0;
    else if (psel && penable && pwrite && pready && paddr == 8'h00)
      aonly_r <= pwdata[1:0] == dams_pkg::MODE_AONLY;
  end
  property p_rdy_next; psel && !penable |=> pready; endproperty
  a_rdy_next: assert property (p_rdy_next)
    else $error("no ready after setup");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one)
    else $error("ready longer than one cycle");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc)
    else $error("ready outside access");
  property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
  a_refuse: assert property (p_refuse)
    else $error("error without ready or with data");
  property p_xtal; $rose(presetn) |-> crystal_osc_select == 3'h7; endproperty
  a_xtal: assert property (p_xtal)
    else $error("analog loops not on crystal after reset");
  property p_idle; aonly_r && $past(aonly_r, 4) |-> digital_active == 3'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("digital loop active in analog-only mode");
  property p_qual0;
    $rose(digital_active[0]) |-> $past(reference_input_valid[0], 5);
  endproperty
  a_qual0: assert property (p_qual0)
    else $error("loop 0 acquired on unqualified reference");
  property p_qual1;
    $rose(digital_active[1]) |-> $past(reference_input_valid[1], 5);
  endproperty
  a_qual1: assert property (p_qual1)
    else $error("loop 1 acquired on unqualified reference");
endmodule : dams_assertions
bind dams_top dams_assertions dams_assertions_inst
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .reference_input_valid(reference_input_valid),
  .crystal_osc_select(crystal_osc_select),
  .digital_active(digital_active)
);

// >>> testbench/dams_ref_model.sv
// model of reference sources, crystal-locked analog loops, phase digitizer
// assumes the bench chooses which references are present
`timescale 1ns/10ps
module dams_ref_model
#(
  parameter int LOCK_DLY = 12
)
(
  // clock and stimulus
  input wire logic pclk,
  input wire logic [2:0] ref_on,
  // from the sequencer
  input wire logic [2:0] analog_loop_enable,
  input wire logic [2:0] digital_active,
  // to the sequencer
  output logic [2:0] reference_input_valid,
  output logic [2:0] analog_lock_in,
  output dams_pkg::dams_phase_t [2:0] phase_time_digitizer
);
  int cnt [3];
  int tick = 0;
  initial
  begin
    reference_input_valid = 3'h0;
    analog_lock_in = 3'h0;
    phase_time_digitizer = '0;
  end
  always @(posedge pclk)
  begin
    tick <= tick + 1;
    reference_input_valid <= ref_on;
    for (int i = 0; i < 3; i++)
    begin
      // lock drops at once when a loop is switched off
      cnt[i] <= analog_loop_enable[i] ? cnt[i] + 1 : 0;
      analog_lock_in[i] <= analog_loop_enable[i] && cnt[i] >= LOCK_DLY;
      phase_time_digitizer[i].valid <= digital_active[i] && tick % 4 == 0;
      // between samples the error lines carry no usable value
      phase_time_digitizer[i].phase_err <=
        (digital_active[i] && tick % 4 == 0) ? 24'sh000140 :
        ~phase_time_digitizer[i].phase_err;
    end
  end
endmodule : dams_ref_model

// >>> testbench/dams_tb_top.sv
// bench: apb scenarios over the pll mode sequencer
// assumes the reference model answers for the analog core
`timescale 1ns/10ps
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("wrong value at %0t: %h, want %h", $time, a, e); \
    end \
  end
`define WAITC(c) \
  begin \
    n = 0; \
    while (!(c) && n < 2000) \
    begin \
      @(posedge pclk); \
      n++; \
    end \
    if (n >= 2000) \
    begin \
      $display("wrong value at %0t: timeout", $time); \
      err_total++; \
      test_done(); \
    end \
  end
module dams_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, ctr, e;
  logic [2:0] ref_on = 3'h0;
  logic [2:0] rv, al, ale, xs, ds, da, nl;
  logic [71:0] num;
  dams_pkg::dams_phase_t [2:0] ptd;
  int n;
  int err_total = 0;
  int samples_checked = 0;
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  dams_top dams_top_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reference_input_valid(rv),
    .analog_lock_in(al), .phase_time_digitizer(ptd),
    .analog_loop_enable(ale), .crystal_osc_select(xs), .center_hold(ctr),
    .denominator_select(ds), .digital_active(da), .numerator_load(nl),
    .numerator(num)
  );
  dams_ref_model dams_ref_model_inst
  (
    .pclk(pclk), .ref_on(ref_on), .analog_loop_enable(ale),
    .digital_active(da), .reference_input_valid(rv), .analog_lock_in(al),
    .phase_time_digitizer(ptd)
  );
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic do_reset();
    presetn <= 1'b0;
    ref_on <= 3'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    `WAITC(pready === 1'b1 && n > 0)
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input logic [31:0] m, input logic [31:0] w);
    int j = 0;
    apb(1'b0, dams_pkg::OFS_STATUS, 32'h0);
    while ((q & m) !== w && j < 200)
    begin
      apb(1'b0, dams_pkg::OFS_STATUS, 32'h0);
      j++;
    end
    `CHK(q & m, w)
  endtask : poll
  task automatic t_regs();
    do_reset();
    apb(1'b0, dams_pkg::OFS_STATUS, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b1, 8'h3C, 32'h5);
    `CHK({e, q}, {1'b1, 32'h0})
    apb(1'b0, dams_pkg::OFS_VALID_TIME, 32'h0);
    `CHK(q, dams_pkg::VALID_TIME_RST)
    `CHK(xs, 3'h7)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_aonly();
    do_reset();
    apb(1'b1, dams_pkg::OFS_MODE, 32'h53);
    apb(1'b1, dams_pkg::OFS_PRIO, 32'h12);
    apb(1'b1, dams_pkg::OFS_ENABLE, 32'h70);
    `WAITC(ale != 3'h0)
    `CHK(ale, 3'b100)
    `WAITC(ale != 3'b100)
    `CHK(ale, 3'b101)
    `WAITC(ale == 3'h7)
    poll(32'h70, 32'h70);
    `CHK({ctr, ds, da, xs}, {1'b0, 3'b101, 3'h0, 3'h7})
    apb(1'b1, dams_pkg::OFS_DCO0, 32'h123456);
    // register lands at the access edge, numerator one edge later
    repeat (2) @(posedge pclk);
    `CHK(nl[0], 1'b1)
    `CHK(num[23:0], 24'h123456)
    $display("t_aonly done");
  endtask : t_aonly
  task automatic t_indep();
    do_reset();
    ref_on <= 3'b001;
    apb(1'b1, dams_pkg::OFS_VALID_TIME, 32'h5);
    apb(1'b1, dams_pkg::OFS_MODE, 32'h0);
    apb(1'b1, dams_pkg::OFS_PRIO, 32'h24);
    apb(1'b1, dams_pkg::OFS_ENABLE, 32'h33);
    `WAITC(da[0])
    `CHK({da[1], ds[0]}, 2'b01)
    `WAITC(nl[0])
    poll(32'h3, 32'h1);
    ref_on <= 3'b011;
    `WAITC(da[1])
    poll(32'h3, 32'h3);
    $display("t_indep done");
  endtask : t_indep
  initial
  begin
    t_regs();
    t_aonly();
    t_indep();
    test_done();
  end
endmodule : dams_tb_top
